// [peia_irq_aggregator.sv]
// event flags, interrupt summary and interrupt pin for two quads
`timescale 1ns/1ps

// Behaviour
// - each event register readable plainly and as a read-clears view.
// - views sit in pairs at 0x02..0x0B and 0x24, plain view first.
// - read-clears view returns flags then clears exactly those returned.
// - unplug summary set by emergency-off flag or any unplugged flag.
// - summary bit is OR of its sources, clears when all are zero.
// - irq_n released when no enabled summary bit on either quad, or by the release command.
// - halt, power-off, reinit, quad reset, shutdown, wipe clear port flags.
// - clearing the last enabled source on both quads releases irq_n.
// - power flags bits 7..4 mark power-good change of ports 4..1.
// - power flags bits 3..0 mark supply-on change of ports 4..1.
// - any power-good change flag sets the power-good summary bit.
// - any supply-on change flag sets the supply-on summary bit.
// - quad request is OR of summary AND mask; either quad pulls irq_n.
// - release command frees irq_n without clearing any flag.
module peia_irq_aggregator
   import peia_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  quad_sel,
   input  wire peia_byte_t            reg_addr,
   input  wire logic                  reg_rd,
   input  wire logic                  reg_wr,
   input  wire peia_byte_t            reg_wdata,
   output peia_byte_t                 reg_rdata,
   output logic                       reg_rvalid,
   input  wire logic [1:0][3:0]       port_pgood,
   input  wire logic [1:0][3:0]       port_supply_on,
   input  wire logic [1:0][7:0]       probe_done_evt,
   input  wire logic [1:0][7:0]       unplug_cut_evt,
   input  wire logic [1:0][7:0]       overcurrent_evt,
   input  wire logic [1:0][7:0]       supply_evt,
   input  wire logic [1:0][7:0]       turn_on_fail_evt,
   input  wire logic [1:0][3:0]       port_op_select_halt,
   input  wire logic [1:0][3:0]       port_pushbutton_off,
   input  wire logic [1:0][3:0]       port_reinit,
   input  wire logic [1:0]            quad_reset,
   input  wire logic [1:0]            wipe_all_flags,
   input  wire logic                  release_irq_pin,
   output logic [1:0][7:0]            irq_summary,
   output logic                       irq_n
);

   // ------------------------------------------------------------
   // storage and helpers
   // ------------------------------------------------------------
   logic [1:0][5:0][7:0] flags;
   logic [1:0][5:0][7:0] set_v;
   logic [1:0][5:0][7:0] clr_v;
   logic [1:0][5:0]      take_v;
   peia_byte_t           mask_r [2];
   logic [1:0][3:0]      pgood_prev_r;
   logic [1:0][3:0]      son_prev_r;
   logic                 primed_r;
   logic [1:0][7:0]      req_v;
   logic [1:0][7:0]      req_prev_r;
   logic                 req_any;
   logic                 req_rise;
   logic                 released_r;
   logic                 released_nxt;
   logic                 irq_n_r;
   peia_byte_t           rdata_r;
   logic                 rvalid_r;
   peia_dec_t            dec;

   function automatic peia_byte_t summary_of(input logic [5:0][7:0] f);
      peia_byte_t s;
      s = '0;
      s[`PEIA_SUM_SUPPLY_ON] = |f[`PEIA_IDX_POWER][3:0];
      s[`PEIA_SUM_PGOOD]     = |f[`PEIA_IDX_POWER][7:4];
      s[`PEIA_SUM_UNPLUG]    = (|f[`PEIA_IDX_UNPLUG][7:4])
                             | f[`PEIA_IDX_SUPPLY][`PEIA_SUP_OFF_BIT];
      s[`PEIA_SUM_DETECT]    = |f[`PEIA_IDX_PROBE][3:0];
      s[`PEIA_SUM_CLASS]     = |f[`PEIA_IDX_PROBE][7:4];
      s[`PEIA_SUM_PI_FAULT]  = (|f[`PEIA_IDX_OVERCUR][7:4])
                             | (|f[`PEIA_IDX_UNPLUG][3:0])
                             | (|f[`PEIA_IDX_SUPPLY][3:2]);
      s[`PEIA_SUM_START]     = (|f[`PEIA_IDX_OVERCUR][3:0])
                             | (|f[`PEIA_IDX_TURNON]);
      // supply bit 0 feeds no summary bit
      s[`PEIA_SUM_SUPPLY]    = |f[`PEIA_IDX_SUPPLY][7:4];
      return s;
   endfunction : summary_of

   assign dec = peia_decode(reg_addr);

   // ------------------------------------------------------------
   // status change detection
   // ------------------------------------------------------------
   // first cycle after reset only samples, so a port already up
   // at release does not look like a change
   always_ff @(posedge clk) begin
      if (rst) begin
         primed_r <= 1'b0;
      end else begin
         primed_r <= 1'b1;
      end
   end

   // last cycle's levels, compared for toggles
   always_ff @(posedge clk) begin
      if (rst) begin
         pgood_prev_r <= '0;
      end else begin
         pgood_prev_r <= port_pgood;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         son_prev_r <= '0;
      end else begin
         son_prev_r <= port_supply_on;
      end
   end

   // ------------------------------------------------------------
   // set, clear and read-take vectors
   // ------------------------------------------------------------
   always_comb begin
      set_v = '0;
      for (int q = 0; q < 2; q++) begin
         set_v[q][`PEIA_IDX_POWER][7:4] = primed_r ?
            (port_pgood[q] ^ pgood_prev_r[q]) : 4'h0;
         set_v[q][`PEIA_IDX_POWER][3:0] = primed_r ?
            (port_supply_on[q] ^ son_prev_r[q]) : 4'h0;
         set_v[q][`PEIA_IDX_PROBE]   = probe_done_evt[q];
         set_v[q][`PEIA_IDX_UNPLUG]  = unplug_cut_evt[q];
         set_v[q][`PEIA_IDX_OVERCUR] = overcurrent_evt[q];
         set_v[q][`PEIA_IDX_SUPPLY]  = supply_evt[q];
         set_v[q][`PEIA_IDX_TURNON]  = turn_on_fail_evt[q];
      end
   end

   always_comb begin
      logic [3:0] pp;
      logic       all_port;
      logic       whole;
      pp       = '0;
      all_port = 1'b0;
      whole    = 1'b0;
      clr_v    = '0;
      for (int q = 0; q < 2; q++) begin
         pp = port_op_select_halt[q] | port_pushbutton_off[q]
            | port_reinit[q];
         whole    = quad_reset[q] | wipe_all_flags[q];
         // emergency off drops every port of its quad
         all_port = whole | supply_evt[q][`PEIA_SUP_OFF_BIT];
         if (all_port) begin
            pp = 4'hf;
         end
         clr_v[q][`PEIA_IDX_PROBE]   = {pp, pp};
         clr_v[q][`PEIA_IDX_UNPLUG]  = {pp, pp};
         clr_v[q][`PEIA_IDX_OVERCUR] = {pp, pp};
         clr_v[q][`PEIA_IDX_SUPPLY][`PEIA_SUP_CUT_LO] = pp[0] | pp[1];
         clr_v[q][`PEIA_IDX_SUPPLY][`PEIA_SUP_CUT_HI] = pp[2] | pp[3];
         if (whole) begin
            for (int i = 0; i < 6; i++) begin
               clr_v[q][i] = 8'hff;
            end
         end
      end
   end

   always_comb begin
      take_v = '0;
      for (int q = 0; q < 2; q++) begin
         for (int i = 0; i < 6; i++) begin
            take_v[q][i] = reg_rd && dec.hit && dec.rc
                        && (dec.idx == 3'(i)) && (quad_sel == 1'(q));
         end
      end
   end

   // ------------------------------------------------------------
   // event registers
   // ------------------------------------------------------------
   // one store behind both views
   for (genvar q = 0; q < 2; q++) begin : g_quad
      for (genvar i = 0; i < 6; i++) begin : g_evt
         peia_event_reg u_evt (
            .clk      (clk),
            .set_bits (set_v[q][i]),
            .clr_bits (clr_v[q][i]),
            .rc_take  (take_v[q][i]),
            .rst      (rst),
            .flags    (flags[q][i])
         );
      end
   end

   // ------------------------------------------------------------
   // mask registers
   // ------------------------------------------------------------
   // only the mask takes writes; the event views are read only
   always_ff @(posedge clk) begin
      if (rst) begin
         mask_r[0] <= `PEIA_RST_MASK;
         mask_r[1] <= `PEIA_RST_MASK;
      end else if (reg_wr && reg_addr == `PEIA_ADDR_MASK) begin
         mask_r[quad_sel] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // summary and interrupt pin
   // ------------------------------------------------------------
   always_comb begin
      for (int q = 0; q < 2; q++) begin
         irq_summary[q] = summary_of(flags[q]);
         req_v[q] = irq_summary[q] & mask_r[q];
      end
      req_any  = |req_v;
      req_rise = |(req_v & ~req_prev_r);
   end

   // release is shared by both quads; a fresh enabled source
   // re-arms the pin, since a held-off pin would hide new events
   always_comb begin
      released_nxt = released_r;
      if (release_irq_pin) begin
         released_nxt = 1'b1;
      end
      if (req_rise || !req_any) begin
         released_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_prev_r <= '0;
      end else begin
         req_prev_r <= req_v;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         released_r <= 1'b0;
      end else begin
         released_r <= released_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_n_r <= 1'b1;
      end else begin
         irq_n_r <= ~(req_any & ~released_nxt);
      end
   end

   assign irq_n = irq_n_r;

   // ------------------------------------------------------------
   // register read port
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid_r <= 1'b0;
      end else begin
         rvalid_r <= reg_rd;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= `PEIA_RST_RDATA;
      end else if (reg_rd) begin
         if (dec.hit) begin
            rdata_r <= flags[quad_sel][dec.idx];
         end else if (reg_addr == `PEIA_ADDR_SUMMARY) begin
            rdata_r <= irq_summary[quad_sel];
         end else if (reg_addr == `PEIA_ADDR_MASK) begin
            rdata_r <= mask_r[quad_sel];
         end else begin
            rdata_r <= `PEIA_RST_RDATA;
         end
      end
   end

   assign reg_rdata  = rdata_r;
   assign reg_rvalid = rvalid_r;

endmodule : peia_irq_aggregator

// [peia_map.svh]
// register offsets, field positions and reset values of the event block
`ifndef PEIA_MAP_SVH
`define PEIA_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PEIA_ADDR_SUMMARY     8'h00
`define PEIA_ADDR_MASK        8'h01
`define PEIA_ADDR_POWER       8'h02
`define PEIA_ADDR_POWER_RC    8'h03
`define PEIA_ADDR_PROBE       8'h04
`define PEIA_ADDR_PROBE_RC    8'h05
`define PEIA_ADDR_UNPLUG      8'h06
`define PEIA_ADDR_UNPLUG_RC   8'h07
`define PEIA_ADDR_OVERCUR     8'h08
`define PEIA_ADDR_OVERCUR_RC  8'h09
`define PEIA_ADDR_SUPPLY      8'h0a
`define PEIA_ADDR_SUPPLY_RC   8'h0b
`define PEIA_ADDR_TURNON      8'h24
`define PEIA_ADDR_TURNON_RC   8'h25

// ---------------------------------------------------------------
// event register indices
// ---------------------------------------------------------------
`define PEIA_IDX_POWER        3'd0
`define PEIA_IDX_PROBE        3'd1
`define PEIA_IDX_UNPLUG       3'd2
`define PEIA_IDX_OVERCUR      3'd3
`define PEIA_IDX_SUPPLY       3'd4
`define PEIA_IDX_TURNON       3'd5

// ---------------------------------------------------------------
// summary bit positions
// ---------------------------------------------------------------
`define PEIA_SUM_SUPPLY_ON    0
`define PEIA_SUM_PGOOD        1
`define PEIA_SUM_UNPLUG       2
`define PEIA_SUM_DETECT       3
`define PEIA_SUM_CLASS        4
`define PEIA_SUM_PI_FAULT     5
`define PEIA_SUM_START        6
`define PEIA_SUM_SUPPLY       7

// ---------------------------------------------------------------
// supply_flags field positions
// ---------------------------------------------------------------
`define PEIA_SUP_OFF_BIT      1
`define PEIA_SUP_CUT_LO       2
`define PEIA_SUP_CUT_HI       3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PEIA_RST_FLAGS        8'h00
`define PEIA_RST_MASK         8'h80
`define PEIA_RST_RDATA        8'h00

`endif

// [peia_pkg.sv]
// types and address decoding shared by the event block
`include "peia_map.svh"

package peia_pkg;

   typedef logic [7:0] peia_byte_t;
   typedef logic [2:0] peia_idx_t;

   typedef struct packed {
      logic      hit;
      logic      rc;
      peia_idx_t idx;
   } peia_dec_t;

   // ------------------------------------------------------------
   // event view decode
   // ------------------------------------------------------------
   function automatic peia_dec_t peia_decode(input peia_byte_t a);
      peia_dec_t d;
      peia_byte_t rel;
      d   = '0;
      rel = a - `PEIA_ADDR_POWER;
      if (a >= `PEIA_ADDR_POWER && a <= `PEIA_ADDR_SUPPLY_RC) begin
         d.hit = 1'b1;
         d.rc  = a[0];
         d.idx = rel[3:1];
      end else if (a == `PEIA_ADDR_TURNON || a == `PEIA_ADDR_TURNON_RC) begin
         d.hit = 1'b1;
         d.rc  = a[0];
         d.idx = `PEIA_IDX_TURNON;
      end
      return d;
   endfunction : peia_decode

endpackage : peia_pkg

// [peia_event_reg.sv]
// one eight-bit sticky event register with clear-on-read
`timescale 1ns/1ps

module peia_event_reg
   import peia_pkg::*;
(
   input  wire logic       clk,
   input  wire peia_byte_t set_bits,
   input  wire peia_byte_t clr_bits,
   input  wire logic       rc_take,
   input  wire logic       rst,
   output peia_byte_t      flags
);

   peia_byte_t flags_r;
   peia_byte_t flags_nxt;
   peia_byte_t clr_all;

   always_comb begin
      clr_all = clr_bits | (rc_take ? flags_r : '0);
      flags_nxt = (flags_r & ~clr_all) | set_bits;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flags_r <= `PEIA_RST_FLAGS;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   assign flags = flags_r;

endmodule : peia_event_reg

// [peia_irq_aggregator_properties.sv]
// port-level checker of the event block
`timescale 1ns/1ps
module peia_irq_aggregator_properties
   import peia_pkg::*;
(
   input wire logic            clk,
   input wire logic            rst,
   input wire logic            reg_rd,
   input wire peia_byte_t      reg_rdata,
   input wire logic            reg_rvalid,
   input wire logic [1:0][7:0] probe_done_evt,
   input wire logic [1:0][7:0] unplug_cut_evt,
   input wire logic [1:0][7:0] overcurrent_evt,
   input wire logic [1:0][7:0] supply_evt,
   input wire logic [1:0][7:0] turn_on_fail_evt,
   input wire logic [1:0][3:0] port_pgood,
   input wire logic [1:0][3:0] port_supply_on,
   input wire logic [1:0]      wipe_all_flags,
   input wire logic            release_irq_pin,
   input wire logic [1:0][7:0] irq_summary,
   input wire logic            irq_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   chk_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   chk_unplug_sum: assert property (
      (unplug_cut_evt[0][4] || supply_evt[0][1]) |=> irq_summary[0][2])
      else $error("unplug summary not set");
   chk_pgood_sum: assert property (
      !$past(rst) && $changed(port_pgood[0]) |=> irq_summary[0][1])
      else $error("power-good summary not set");
   chk_enable_sum: assert property (
      !$past(rst) && $changed(port_supply_on[1]) |=> irq_summary[1][0])
      else $error("supply-on summary not set");
   chk_wipe_all: assert property (
      wipe_all_flags[0] && $stable(port_pgood[0])
      && $stable(port_supply_on[0]) && !(|{probe_done_evt[0],
      unplug_cut_evt[0], overcurrent_evt[0], supply_evt[0],
      turn_on_fail_evt[0]}) |=> irq_summary[0] == 8'h00)
      else $error("wipe left flags set");
   chk_irq_idle: assert property (irq_summary == '0 |=> irq_n)
      else $error("irq pin held without request");
   chk_irq_release: assert property (
      release_irq_pin && !reg_rd && $stable(irq_summary)
      |=> irq_n && $stable(irq_summary))
      else $error("release failed or cleared flags");
endmodule : peia_irq_aggregator_properties

bind peia_irq_aggregator peia_irq_aggregator_properties
   peia_irq_aggregator_properties_i (.clk, .rst, .reg_rd, .reg_rdata,
   .reg_rvalid, .probe_done_evt, .unplug_cut_evt, .overcurrent_evt,
   .supply_evt, .turn_on_fail_evt, .port_pgood, .port_supply_on,
   .wipe_all_flags, .release_irq_pin, .irq_summary, .irq_n);

// [peia_host_model.sv]
// host model driving the register port at falling edges
`timescale 1ns/1ps
module peia_host_model
   import peia_pkg::*;
(
   input  wire logic       clk,
   input  wire peia_byte_t reg_rdata,
   input  wire logic       reg_rvalid,
   output logic            quad_sel = 1'b0,
   output peia_byte_t      reg_addr = 8'h00,
   output logic            reg_rd = 1'b0,
   output logic            reg_wr = 1'b0,
   output peia_byte_t      reg_wdata = 8'h00
);
   // idle address and data inverted so stale values never pass
   task automatic rd(input logic q, input peia_byte_t a, output peia_byte_t v,
                     output logic ok);
      quad_sel = q;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      v        = reg_rdata;
      ok       = reg_rvalid;
      // idle edge, so a next call never re-raises a strobe in this step
      @(negedge clk);
   endtask : rd
   task automatic wr(input logic q, input peia_byte_t a, input peia_byte_t d);
      quad_sel  = q;
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
      @(negedge clk);
   endtask : wr
endmodule : peia_host_model

// [peia_irq_aggregator_tb.sv]
// self-checking bench of the event block
`timescale 1ns/1ps
module peia_irq_aggregator_tb import peia_pkg::*;;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic quad_sel, reg_rd, reg_wr, reg_rvalid, irq_n, ok;
   peia_byte_t reg_addr, reg_wdata, reg_rdata, v, a;
   logic [1:0][3:0] port_pgood = '0, port_supply_on = '0;
   logic [1:0][3:0] port_op_select_halt = '0, port_pushbutton_off = '0;
   logic [1:0][3:0] port_reinit = '0;
   logic [1:0][7:0] probe_done_evt = '0, unplug_cut_evt = '0;
   logic [1:0][7:0] overcurrent_evt = '0, supply_evt = '0;
   logic [1:0][7:0] turn_on_fail_evt = '0, irq_summary;
   logic [1:0] quad_reset = '0, wipe_all_flags = '0;
   logic release_irq_pin = 1'b0;
   peia_byte_t sum_exp [5] = '{8'h18, 8'h24, 8'h60, 8'h80, 8'h40};
   int err_count = 0;
   int samples_checked = 0;

   always #4 clk = ~clk;

   peia_irq_aggregator peia_irq_aggregator_i (.clk, .rst, .quad_sel,
      .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid,
      .port_pgood, .port_supply_on, .probe_done_evt, .unplug_cut_evt,
      .overcurrent_evt, .supply_evt, .turn_on_fail_evt, .port_op_select_halt,
      .port_pushbutton_off, .port_reinit, .quad_reset, .wipe_all_flags,
      .release_irq_pin, .irq_summary, .irq_n);
   peia_host_model peia_host_model_i (.clk, .reg_rdata, .reg_rvalid,
      .quad_sel, .reg_addr, .reg_rd, .reg_wr, .reg_wdata);

   task automatic cmp(input string n, input peia_byte_t e, input peia_byte_t g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic rdc(input logic q, input peia_byte_t ad, input peia_byte_t e);
      peia_host_model_i.rd(q, ad, v, ok);
      cmp("rvalid", 8'h01, {7'b0, ok});
      cmp($sformatf("q%0d reg %h", q, ad), e, v);
      cmp("rvalid idle", 8'h00, {7'b0, reg_rvalid});
   endtask : rdc
   task automatic ev(input int k, input logic q, input peia_byte_t b);
      case (k)
         0: probe_done_evt[q] = b;
         1: unplug_cut_evt[q] = b;
         2: overcurrent_evt[q] = b;
         3: supply_evt[q] = b;
         default: turn_on_fail_evt[q] = b;
      endcase
   endtask : ev
   task automatic pulse(input int k, input logic q, input peia_byte_t b);
      ev(k, q, b);
      @(negedge clk);
      ev(k, q, 8'h00);
   endtask : pulse
   // one clearing action on quad 0: port 1 for halt, power-off, reinit; whole quad for quad reset and wipe; every port for emergency off
   task automatic clr(input int k);
      case (k)
         0: port_op_select_halt[0][0] = 1'b1;
         1: port_pushbutton_off[0][0] = 1'b1;
         2: port_reinit[0][0] = 1'b1;
         3: quad_reset[0] = 1'b1;
         4: wipe_all_flags[0] = 1'b1;
         default: supply_evt[0] = 8'h02;
      endcase
      @(negedge clk);
      {port_op_select_halt, port_pushbutton_off, port_reinit} = '0;
      {quad_reset, wipe_all_flags} = '0;
      supply_evt = '0;
   endtask : clr
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize

   initial begin
      repeat (5000) @(posedge clk);
      err_count++;
      summarize();
   end

   initial begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rdc(0, 8'h02, 8'h00);
      rdc(0, 8'h03, 8'h00);
      rdc(1, 8'h01, 8'h80);
      $display("test reset done");
      port_pgood[0][2] = 1'b1;
      port_supply_on[1][1] = 1'b1;
      repeat (2) @(negedge clk);
      rdc(0, 8'h02, 8'h40);
      rdc(1, 8'h02, 8'h02);
      rdc(0, 8'h02, 8'h40);
      cmp("sum q0", 8'h02, irq_summary[0]);
      cmp("sum q1", 8'h01, irq_summary[1]);
      cmp("irq_n", 8'h01, {7'b0, irq_n});
      rdc(0, 8'h03, 8'h40);
      rdc(1, 8'h03, 8'h02);
      rdc(0, 8'h02, 8'h00);
      $display("test power done");
      for (int q = 0; q < 2; q++) for (int k = 0; k < 5; k++) begin
         a = (k == 4) ? 8'h24 : 8'(4 + 2 * k);
         pulse(k, q[0], 8'h81);
         cmp("summary", sum_exp[k], irq_summary[q]);
         rdc(q[0], a, 8'h81);
         cmp("irq_n", {7'b0, k != 3}, {7'b0, irq_n});
         rdc(q[0], a | 8'h01, 8'h81);
         rdc(q[0], a, 8'h00);
         cmp("irq_n", 8'h01, {7'b0, irq_n});
      end
      $display("test views done");
      peia_host_model_i.wr(0, 8'h01, 8'h04);
      peia_host_model_i.wr(0, 8'h02, 8'hff);
      rdc(0, 8'h01, 8'h04);
      rdc(0, 8'h30, 8'h00);
      pulse(3, 0, 8'h02);
      pulse(1, 0, 8'h10);
      rdc(0, 8'h0b, 8'h02);
      cmp("sum q0", 8'h04, irq_summary[0]);
      cmp("irq_n", 8'h00, {7'b0, irq_n});
      rdc(0, 8'h07, 8'h10);
      @(negedge clk);
      cmp("irq_n", 8'h01, {7'b0, irq_n});
      $display("test unplug done");
      ev(2, 0, 8'h02);
      @(negedge clk);
      ev(2, 0, 8'h01);
      rdc(0, 8'h09, 8'h02);
      ev(2, 0, 8'h00);
      rdc(0, 8'h08, 8'h01);
      rdc(0, 8'h09, 8'h01);
      for (int k = 0; k < 6; k++) begin
         pulse(0, 0, 8'h11);
         clr(k);
         rdc(0, 8'h04, 8'h00);
      end
      rdc(0, 8'h0b, 8'h02);
      $display("test clears done");
      pulse(3, 1, 8'h80);
      @(negedge clk);
      cmp("irq_n", 8'h00, {7'b0, irq_n});
      release_irq_pin = 1'b1;
      @(negedge clk);
      release_irq_pin = 1'b0;
      @(negedge clk);
      cmp("irq_n", 8'h01, {7'b0, irq_n});
      cmp("sum q1", 8'h80, irq_summary[1]);
      rdc(1, 8'h0b, 8'h80);
      $display("test release done");
      summarize();
   end
endmodule : peia_irq_aggregator_tb
